// ==== crpc_pkg.sv ====
package crpc_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_CARD_SELECT = 6'h00;
  localparam logic [5:0] IDX_CARD_CLOCK_CONFIG = 6'h01;
  localparam logic [5:0] IDX_CLOCK_DIVIDER_VALUE = 6'h02;
  localparam logic [5:0] IDX_UART_CONTROL_TWO = 6'h03;
  localparam logic [5:0] IDX_GUARD_TIME = 6'h05;
  localparam logic [5:0] IDX_UART_CONTROL_ONE = 6'h06;
  localparam logic [5:0] IDX_POWER_CONTROL = 6'h07;
  localparam logic [5:0] IDX_TIMEOUT_CONFIG = 6'h08;
  localparam logic [5:0] IDX_TIMEOUT_RELOAD_LOW = 6'h09;
  localparam logic [5:0] IDX_TIMEOUT_RELOAD_MID = 6'h0a;
  localparam logic [5:0] IDX_TIMEOUT_RELOAD_HIGH = 6'h0b;
  localparam logic [5:0] IDX_FIFO_MIXED = 6'h0c;
  localparam logic [5:0] IDX_UART_DATA = 6'h0d;
  localparam logic [5:0] IDX_UART_STATUS = 6'h0e;
  localparam logic [5:0] IDX_HARDWARE_STATUS = 6'h0f;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h11;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CS_RESET_RELEASE = 3;
  localparam int PC_START = 0;
  localparam int PC_THREE_VOLT = 1;
  localparam int PC_RESET_LEVEL = 2;
  localparam int PC_LOW_VOLTAGE = 3;
  localparam int UC1_TX_RX = 3;
  localparam int UC1_LAST_CHAR = 2;
  localparam int MS_PRESENT = 2;
  localparam int HS_SUPPLY_LOW = 4;
  localparam int HS_PRES_TOGGLE = 2;
  localparam int IRQ_EMERGENCY = 0;
  localparam int IRQ_ACTIVATED = 1;
  localparam int IRQ_DEACTIVATED = 2;
  localparam int IRQ_PRESENCE = 3;

  // ---------------------------------------------------------------
  // Reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] MASK_POWER_CONTROL = 8'h0f;
  localparam logic [7:0] MASK_CARD_CLOCK = 8'h3f;
  localparam logic [7:0] MASK_UART_ONE = 8'h7f;
  localparam logic [7:0] MASK_FIFO_CONTROL = 8'h77;
  localparam logic [7:0] MASK_CARD_SELECT = 8'h08;
  localparam logic [3:0] MASK_IRQ = 4'hf;

  // ---------------------------------------------------------------
  // Supply select encodings and sequencer timing
  // ---------------------------------------------------------------
  localparam logic [1:0] VSEL_5V = 2'h0;
  localparam logic [1:0] VSEL_3V = 2'h1;
  localparam logic [1:0] VSEL_1V8 = 2'h2;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STEP_TIME_NS = 1000;
  localparam int STEP_CYCLES =
    (STEP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_CONV, SEQ_RAMP, SEQ_IO, SEQ_ACTIVE,
    SEQ_D_RST, SEQ_D_IO, SEQ_D_VCC
  } crpc_seq_type;

endpackage

// ==== crpc_regs.sv ====
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module crpc_regs #(
  parameter int STEP_CYCLES = crpc_pkg::STEP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic card_present,
  input wire logic supply_ok,
  input wire logic fault_overcurrent,
  input wire logic fault_overheat,
  input wire logic rx_strobe,
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] uart_status_in,
  input wire logic last_char_done,
  output logic conv_en,
  output logic vcc_en,
  output logic [1:0] vcc_sel,
  output logic io_en,
  output logic card_clk_en,
  output logic card_rst,
  output logic [7:0] tx_byte,
  output logic tx_strobe,
  output logic [23:0] timeout_reload,
  output logic [7:0] timeout_config,
  output logic [7:0] card_clock_config,
  output logic [7:0] fifo_control,
  output logic irq
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic [3:0] pin_s3_ff;
  logic [3:0] pin_ff;
  assign pin_raw = {fault_overheat, fault_overcurrent, supply_ok,
                    card_present};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_s1_ff[gi] <= 1'b0;
          pin_s2_ff[gi] <= 1'b0;
          pin_s3_ff[gi] <= 1'b0;
          pin_ff[gi] <= 1'b0;
        end else begin
          pin_s1_ff[gi] <= pin_raw[gi];
          pin_s2_ff[gi] <= pin_s1_ff[gi];
          pin_s3_ff[gi] <= pin_s2_ff[gi];
          // Glitch filter: counted once two stages agree
          if (pin_s2_ff[gi] == pin_s3_ff[gi]) begin
            pin_ff[gi] <= pin_s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  logic present;
  logic supply_good;
  logic fault;
  assign present = pin_ff[0];
  assign supply_good = pin_ff[1];
  assign fault = pin_ff[2] | pin_ff[3];

  // ---------------------------------------------------------------
  // APB access
  // ---------------------------------------------------------------
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [5:0] idx;
  logic acc;
  logic wr_en;
  logic rd_en;
  logic [7:0] wdata;
  assign idx = paddr[7:2];
  assign acc = psel & penable & pready_ff;
  assign wr_en = acc & pwrite;
  assign rd_en = acc & ~pwrite;
  assign wdata = pwdata[7:0];

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0] csr_ff, ccr_ff, pdr_ff, uart_control_two_ff, gtr_ff, uart_control_one_ff, pcr_ff;
  logic [7:0] toc_ff, timeout_reload_low_ff, timeout_reload_mid_ff, timeout_reload_high_ff, fcr_ff;
  logic [7:0] urr_ff, utr_ff, usr_ff;
  logic [3:0] irq_stat_ff, irq_mask_ff;
  logic supl_ff, prl_ff, pres_d_ff, tx_strobe_ff, irq_ff;
  logic card_interface_reset_release;
  assign card_interface_reset_release = csr_ff[crpc_pkg::CS_RESET_RELEASE];

  crpc_pkg::crpc_seq_type state_ff;
  logic session_on, emergency, ok_to_start, start_req, stop_req;
  logic pcr_wr;
  assign session_on = (state_ff == crpc_pkg::SEQ_CONV) ||
    (state_ff == crpc_pkg::SEQ_RAMP) || (state_ff == crpc_pkg::SEQ_IO) ||
    (state_ff == crpc_pkg::SEQ_ACTIVE);
  assign emergency = session_on & (~present | ~supply_good | fault);
  assign ok_to_start = present & supply_good & ~fault;
  assign pcr_wr = wr_en && (idx == crpc_pkg::IDX_POWER_CONTROL);
  assign start_req = pcr_wr && wdata[crpc_pkg::PC_START] &&
    (state_ff == crpc_pkg::SEQ_IDLE) && ok_to_start;
  assign stop_req = pcr_wr && !wdata[crpc_pkg::PC_START] && session_on;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_ff <= crpc_pkg::RST_REG;
      ccr_ff <= crpc_pkg::RST_REG;
      pdr_ff <= crpc_pkg::RST_REG;
      uart_control_two_ff <= crpc_pkg::RST_REG;
      gtr_ff <= crpc_pkg::RST_REG;
      fcr_ff <= crpc_pkg::RST_REG;
      timeout_reload_low_ff <= crpc_pkg::RST_REG;
      timeout_reload_mid_ff <= crpc_pkg::RST_REG;
      timeout_reload_high_ff <= crpc_pkg::RST_REG;
    end else if (wr_en) begin
      case (idx)
        crpc_pkg::IDX_CARD_SELECT:
          csr_ff <= wdata & crpc_pkg::MASK_CARD_SELECT;
        crpc_pkg::IDX_CARD_CLOCK_CONFIG:
          ccr_ff <= wdata & crpc_pkg::MASK_CARD_CLOCK;
        crpc_pkg::IDX_CLOCK_DIVIDER_VALUE: pdr_ff <= wdata;
        crpc_pkg::IDX_UART_CONTROL_TWO: uart_control_two_ff <= wdata;
        crpc_pkg::IDX_GUARD_TIME: gtr_ff <= wdata;
        crpc_pkg::IDX_FIFO_MIXED:
          fcr_ff <= wdata & crpc_pkg::MASK_FIFO_CONTROL;
        crpc_pkg::IDX_TIMEOUT_RELOAD_LOW: timeout_reload_low_ff <= wdata;
        crpc_pkg::IDX_TIMEOUT_RELOAD_MID: timeout_reload_mid_ff <= wdata;
        crpc_pkg::IDX_TIMEOUT_RELOAD_HIGH: timeout_reload_high_ff <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toc_ff <= crpc_pkg::RST_REG;
      urr_ff <= crpc_pkg::RST_REG;
      utr_ff <= crpc_pkg::RST_REG;
      usr_ff <= crpc_pkg::RST_REG;
      uart_control_one_ff <= crpc_pkg::RST_REG;
      tx_strobe_ff <= 1'b0;
    end else if (!card_interface_reset_release) begin
      toc_ff <= crpc_pkg::RST_REG;
      urr_ff <= crpc_pkg::RST_REG;
      utr_ff <= crpc_pkg::RST_REG;
      usr_ff <= crpc_pkg::RST_REG;
      // Other mode bits stay writable while the interface is held
      if (wr_en && idx == crpc_pkg::IDX_UART_CONTROL_ONE) begin
        uart_control_one_ff <= wdata & crpc_pkg::MASK_UART_ONE;
      end
      uart_control_one_ff[crpc_pkg::UC1_TX_RX] <= 1'b0;
      uart_control_one_ff[crpc_pkg::UC1_LAST_CHAR] <= 1'b0;
      tx_strobe_ff <= 1'b0;
    end else begin
      usr_ff <= uart_status_in;
      if (rx_strobe) begin
        urr_ff <= rx_byte;
      end
      if (wr_en && idx == crpc_pkg::IDX_TIMEOUT_CONFIG) begin
        toc_ff <= wdata;
      end
      // Transmit takes writes, receive answers reads
      tx_strobe_ff <= wr_en && (idx == crpc_pkg::IDX_UART_DATA);
      if (wr_en && idx == crpc_pkg::IDX_UART_DATA) begin
        utr_ff <= wdata;
      end
      if (wr_en && idx == crpc_pkg::IDX_UART_CONTROL_ONE) begin
        uart_control_one_ff <= wdata & crpc_pkg::MASK_UART_ONE;
      end else if (last_char_done && uart_control_one_ff[crpc_pkg::UC1_LAST_CHAR]) begin
        // End of last character returns the UART to reception
        uart_control_one_ff[crpc_pkg::UC1_TX_RX] <= 1'b0;
        uart_control_one_ff[crpc_pkg::UC1_LAST_CHAR] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcr_ff <= crpc_pkg::RST_REG;
    end else if (emergency) begin
      // Hardware clear beats a same-cycle write
      pcr_ff[crpc_pkg::PC_START] <= 1'b0;
    end else if (pcr_wr) begin
      pcr_ff <= wdata & crpc_pkg::MASK_POWER_CONTROL;
      // Refused start leaves the bit low
      if (wdata[crpc_pkg::PC_START] && !start_req && !session_on) begin
        pcr_ff[crpc_pkg::PC_START] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Activation / deactivation sequencer
  // ---------------------------------------------------------------
  logic [15:0] timer_ff;
  logic step_done;
  assign step_done = (timer_ff == 16'(STEP_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= crpc_pkg::SEQ_IDLE;
      timer_ff <= 16'h0000;
    end else begin
      timer_ff <= step_done ? 16'h0000 : timer_ff + 16'h0001;
      case (state_ff)
        crpc_pkg::SEQ_IDLE: begin
          timer_ff <= 16'h0000;
          if (start_req) begin
            state_ff <= crpc_pkg::SEQ_CONV;
          end
        end
        crpc_pkg::SEQ_CONV, crpc_pkg::SEQ_RAMP, crpc_pkg::SEQ_IO: begin
          if (emergency || stop_req) begin
            state_ff <= crpc_pkg::SEQ_D_RST;
            timer_ff <= 16'h0000;
          end else if (step_done) begin
            state_ff <= (state_ff == crpc_pkg::SEQ_CONV) ?
              crpc_pkg::SEQ_RAMP : (state_ff == crpc_pkg::SEQ_RAMP) ?
              crpc_pkg::SEQ_IO : crpc_pkg::SEQ_ACTIVE;
          end
        end
        crpc_pkg::SEQ_ACTIVE: begin
          timer_ff <= 16'h0000;
          if (emergency || stop_req) begin
            state_ff <= crpc_pkg::SEQ_D_RST;
          end
        end
        crpc_pkg::SEQ_D_RST: begin
          if (step_done) begin
            state_ff <= crpc_pkg::SEQ_D_IO;
          end
        end
        crpc_pkg::SEQ_D_IO: begin
          if (step_done) begin
            state_ff <= crpc_pkg::SEQ_D_VCC;
          end
        end
        crpc_pkg::SEQ_D_VCC: begin
          if (step_done) begin
            state_ff <= crpc_pkg::SEQ_IDLE;
          end
        end
        default: state_ff <= crpc_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Contact drivers; reset and clock drop in the same cycle, ahead of I/O and supply
  logic conv_ff, vcc_ff, io_ff, clk_ff, rst_ff;
  logic [1:0] vsel_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_ff <= 1'b0;
      vcc_ff <= 1'b0;
      io_ff <= 1'b0;
      clk_ff <= 1'b0;
      rst_ff <= 1'b0;
    end else begin
      conv_ff <= (state_ff != crpc_pkg::SEQ_IDLE);
      vcc_ff <= session_on && state_ff != crpc_pkg::SEQ_CONV ||
        state_ff == crpc_pkg::SEQ_D_RST || state_ff == crpc_pkg::SEQ_D_IO ||
        state_ff == crpc_pkg::SEQ_D_VCC;
      io_ff <= state_ff == crpc_pkg::SEQ_IO ||
        state_ff == crpc_pkg::SEQ_ACTIVE || state_ff == crpc_pkg::SEQ_D_RST;
      clk_ff <= (state_ff == crpc_pkg::SEQ_ACTIVE);
      // Reset contact copies the level bit only in SEQ_ACTIVE
      rst_ff <= (state_ff == crpc_pkg::SEQ_ACTIVE) &&
        pcr_ff[crpc_pkg::PC_RESET_LEVEL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vsel_ff <= crpc_pkg::VSEL_5V;
    end else if (pcr_ff[crpc_pkg::PC_LOW_VOLTAGE]) begin
      vsel_ff <= crpc_pkg::VSEL_1V8;
    end else begin
      vsel_ff <= pcr_ff[crpc_pkg::PC_THREE_VOLT] ? crpc_pkg::VSEL_3V :
        crpc_pkg::VSEL_5V;
    end
  end

  // ---------------------------------------------------------------
  // Hardware status and interrupts
  // ---------------------------------------------------------------
  logic hsr_rd, pres_tgl, act_evt, deact_evt;
  logic [3:0] irq_evt;
  assign hsr_rd = rd_en && (idx == crpc_pkg::IDX_HARDWARE_STATUS);
  assign pres_tgl = present ^ pres_d_ff;
  assign act_evt = (state_ff == crpc_pkg::SEQ_IO) && step_done &&
    !emergency && !stop_req;
  assign deact_evt = (state_ff == crpc_pkg::SEQ_D_VCC) && step_done;
  assign irq_evt = {pres_tgl, deact_evt, act_evt, emergency};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pres_d_ff <= 1'b0;
      supl_ff <= 1'b0;
      prl_ff <= 1'b0;
    end else begin
      pres_d_ff <= present;
      // Sticky until read; a new event in the read cycle is kept
      supl_ff <= !supply_good || (supl_ff && !hsr_rd);
      prl_ff <= pres_tgl || (prl_ff && !hsr_rd);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= 4'h0;
      irq_mask_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_en && idx == crpc_pkg::IDX_IRQ_STATUS) begin
        irq_stat_ff <= (irq_stat_ff & ~wdata[3:0]) | irq_evt;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_evt;
      end
      if (wr_en && idx == crpc_pkg::IDX_IRQ_MASK) begin
        irq_mask_ff <= wdata[3:0] & crpc_pkg::MASK_IRQ;
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ---------------------------------------------------------------
  // Read mux and APB answer
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;
  logic bad;
  always_comb begin
    rd_mux = 8'h00;
    bad = 1'b0;
    case (idx)
      crpc_pkg::IDX_CARD_SELECT: rd_mux = csr_ff;
      crpc_pkg::IDX_CARD_CLOCK_CONFIG: rd_mux = ccr_ff;
      crpc_pkg::IDX_CLOCK_DIVIDER_VALUE: rd_mux = pdr_ff;
      crpc_pkg::IDX_UART_CONTROL_TWO: rd_mux = uart_control_two_ff;
      crpc_pkg::IDX_GUARD_TIME: rd_mux = gtr_ff;
      crpc_pkg::IDX_UART_CONTROL_ONE: rd_mux = uart_control_one_ff;
      crpc_pkg::IDX_POWER_CONTROL: rd_mux = pcr_ff;
      crpc_pkg::IDX_TIMEOUT_CONFIG: rd_mux = toc_ff;
      crpc_pkg::IDX_TIMEOUT_RELOAD_LOW, crpc_pkg::IDX_TIMEOUT_RELOAD_MID,
      crpc_pkg::IDX_TIMEOUT_RELOAD_HIGH: rd_mux = 8'h00;
      crpc_pkg::IDX_FIFO_MIXED: rd_mux[crpc_pkg::MS_PRESENT] = present;
      crpc_pkg::IDX_UART_DATA: rd_mux = urr_ff;
      crpc_pkg::IDX_UART_STATUS: begin
        rd_mux = usr_ff;
        bad = pwrite;
      end
      crpc_pkg::IDX_HARDWARE_STATUS: begin
        rd_mux[crpc_pkg::HS_SUPPLY_LOW] = supl_ff;
        rd_mux[crpc_pkg::HS_PRES_TOGGLE] = prl_ff;
        bad = pwrite;
      end
      crpc_pkg::IDX_IRQ_STATUS: rd_mux = {4'h0, irq_stat_ff};
      crpc_pkg::IDX_IRQ_MASK: rd_mux = {4'h0, irq_mask_ff};
      default: bad = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
      prdata_ff <= (psel & penable & ~pready_ff & ~pwrite) ?
        {24'h00_0000, rd_mux} : 32'h0000_0000;
      pslverr_ff <= psel & penable & ~pready_ff & bad;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign conv_en = conv_ff;
  assign vcc_en = vcc_ff;
  assign vcc_sel = vsel_ff;
  assign io_en = io_ff;
  assign card_clk_en = clk_ff;
  assign card_rst = rst_ff;
  assign tx_byte = utr_ff;
  assign tx_strobe = tx_strobe_ff;
  assign timeout_reload = {timeout_reload_high_ff, timeout_reload_mid_ff, timeout_reload_low_ff};
  assign timeout_config = toc_ff;
  assign card_clock_config = ccr_ff;
  assign fifo_control = fcr_ff;
  assign irq = irq_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_start_taken;
    start_req;
  endsequence
  sequence s_power_up;
    state_ff == crpc_pkg::SEQ_CONV ##1 conv_ff;
  endsequence

  a_start_launch: assert property (@(posedge pclk) disable iff (!presetn)
    s_start_taken |=> s_power_up) else $error("start not launched");
  a_stop_deact: assert property (@(posedge pclk) disable iff (!presetn)
    stop_req && !emergency |=> state_ff == crpc_pkg::SEQ_D_RST ##1 !clk_ff)
    else $error("stop did not deactivate");
  a_emerg_clear: assert property (@(posedge pclk) disable iff (!presetn)
    emergency |=> !pcr_ff[crpc_pkg::PC_START] ##1 !rst_ff)
    else $error("emergency left start set");
  a_rst_copy: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == crpc_pkg::SEQ_ACTIVE |=>
      rst_ff == $past(pcr_ff[crpc_pkg::PC_RESET_LEVEL]))
    else $error("reset contact not copied");
  a_low_volt: assert property (@(posedge pclk) disable iff (!presetn)
    pcr_ff[crpc_pkg::PC_LOW_VOLTAGE] |=> vsel_ff == crpc_pkg::VSEL_1V8)
    else $error("low voltage not selected");
  a_three_five: assert property (@(posedge pclk) disable iff (!presetn)
    !pcr_ff[crpc_pkg::PC_LOW_VOLTAGE] |=> vsel_ff ==
      ($past(pcr_ff[crpc_pkg::PC_THREE_VOLT]) ? crpc_pkg::VSEL_3V :
       crpc_pkg::VSEL_5V)) else $error("wrong THREE_VOLT_SELECT supply");
  a_riu_force: assert property (@(posedge pclk) disable iff (!presetn)
    !card_interface_reset_release |=> toc_ff == 8'h00 && urr_ff == 8'h00 && utr_ff == 8'h00 &&
      usr_ff == 8'h00 && !uart_control_one_ff[crpc_pkg::UC1_TX_RX] &&
      !uart_control_one_ff[crpc_pkg::UC1_LAST_CHAR]) else $error("reset force missing");
  a_shared_wr: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && card_interface_reset_release && idx == crpc_pkg::IDX_UART_DATA |=>
      utr_ff == $past(wdata) && tx_strobe_ff)
    else $error("transmit write lost");
  a_start_gate: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == crpc_pkg::SEQ_IDLE ##1 state_ff == crpc_pkg::SEQ_CONV |->
      $past(present) && $past(supply_good)) else $error("bad activation");
  a_power_order: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(clk_ff) |-> io_ff && vcc_ff && conv_ff)
    else $error("power-up out of order");

endmodule

// ==== crpc_card_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Card in the slot with its contact and supply sensing
// ---------------------------------------------------------------
module crpc_card_model (
  input wire logic insert,
  input wire logic supply_good,
  input wire logic short_cmd,
  input wire logic vcc_en,
  output logic card_present,
  output logic supply_ok,
  output logic fault_overcurrent,
  output logic fault_overheat
);
  assign card_present = insert;
  assign supply_ok = supply_good;
  // A shorted card only overloads once its supply is switched on
  assign fault_overcurrent = vcc_en & short_cmd;
  assign fault_overheat = 1'b0;
endmodule

// ==== card_reader_power_control_regs_tb_top.sv ====
`timescale 1ns/1ps
module card_reader_power_control_regs_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic [7:0] paddr, rx_byte, uart_status_in, tx_byte, rd;
  logic [31:0] pwdata, prdata;
  logic rx_strobe, last_char_done, tx_strobe, insert, good, short_cmd;
  logic card_present, supply_ok, fault_overcurrent, fault_overheat;
  logic conv_en, vcc_en, io_en, card_clk_en, card_rst;
  logic [1:0] vcc_sel;
  logic [23:0] timeout_reload;
  logic [7:0] timeout_config, card_clock_config, fifo_control;
  logic [7:0] vals [4] = '{8'h00, 8'h02, 8'h08, 8'h0a};
  logic [7:0] sels [4] = '{8'h00, 8'h01, 8'h02, 8'h02};
  int fails, checks, cyc;

  crpc_regs #(.STEP_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .card_present(card_present), .supply_ok(supply_ok),
    .fault_overcurrent(fault_overcurrent), .fault_overheat(fault_overheat),
    .rx_strobe(rx_strobe), .rx_byte(rx_byte),
    .uart_status_in(uart_status_in), .last_char_done(last_char_done),
    .conv_en(conv_en), .vcc_en(vcc_en), .vcc_sel(vcc_sel), .io_en(io_en),
    .card_clk_en(card_clk_en), .card_rst(card_rst), .tx_byte(tx_byte),
    .tx_strobe(tx_strobe), .timeout_reload(timeout_reload),
    .timeout_config(timeout_config), .card_clock_config(card_clock_config),
    .fifo_control(fifo_control), .irq(irq));

  crpc_card_model card_u (.insert(insert), .supply_good(good),
    .short_cmd(short_cmd), .vcc_en(vcc_en), .card_present(card_present),
    .supply_ok(supply_ok), .fault_overcurrent(fault_overcurrent),
    .fault_overheat(fault_overheat));

  // ---------------------------------------------------------------
  // Bus cycles, waits and checks
  // ---------------------------------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // No wait limit here; the cycle ceiling ends a hung bus
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded, so a stuck sequencer shows up as a failed check
  task wait_on(input logic up);
    int n;
    n = 0;
    while ((up ? card_clk_en : conv_en) !== up && n < 100) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task results;
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      results;
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, rx_strobe, last_char_done} = '0;
    {paddr, rx_byte, pwdata, insert, short_cmd} = '0;
    {fails, checks} = '0;
    good = 1'b1;
    uart_status_in = 8'h81;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h1c, 8'h00); chk(rd, 8'h00);
    apb(1, 8'h20, 8'h5a); apb(0, 8'h20, 8'h00); chk(rd, 8'h00);
    apb(1, 8'h18, 8'h7f); apb(0, 8'h18, 8'h00); chk(rd, 8'h73);
    apb(0, 8'h38, 8'h00); chk(rd, 8'h00);
    apb(1, 8'h00, 8'h08); apb(1, 8'h20, 8'h5a);
    apb(0, 8'h20, 8'h00); chk(rd, 8'h5a);
    apb(0, 8'h38, 8'h00); chk(rd, 8'h81);
    apb(1, 8'h18, 8'h7f);
    last_char_done <= 1'b1;
    @(posedge pclk);
    last_char_done <= 1'b0;
    apb(0, 8'h18, 8'h00); chk(rd, 8'h73);
    apb(1, 8'h24, 8'h11);
    apb(1, 8'h28, 8'h22);
    apb(1, 8'h2c, 8'h33);
    apb(1, 8'h04, 8'hff);
    apb(1, 8'h30, 8'hff);
    chk(timeout_config, 8'h5a);
    apb(1, 8'h34, 8'ha5); @(posedge pclk);
    chk(8'(tx_strobe), 8'h01);
    chk(tx_byte, 8'ha5);
    rx_byte <= 8'h3c;
    rx_strobe <= 1'b1;
    @(posedge pclk);
    rx_strobe <= 1'b0;
    apb(0, 8'h34, 8'h00); chk(rd, 8'h3c);
    apb(1, 8'h00, 8'h00); apb(0, 8'h34, 8'h00); chk(rd, 8'h00);
    apb(0, 8'h20, 8'h00); chk(rd, 8'h00);
    chk(timeout_config, 8'h00);
    chk(timeout_reload[23:16], 8'h33);
    chk(timeout_reload[15:8], 8'h22);
    chk(timeout_reload[7:0], 8'h11);
    chk(card_clock_config, 8'h3f);
    chk(fifo_control, 8'h77);
    apb(1, 8'h00, 8'h08);
    for (int i = 0; i < 4; i++) begin
      apb(1, 8'h1c, vals[i]); repeat (2) @(posedge pclk);
      chk(8'(vcc_sel), sels[i]);
    end
    apb(1, 8'h1c, 8'h01); apb(0, 8'h1c, 8'h00); chk(rd, 8'h00);
    chk(8'(conv_en), 8'h00);
    insert <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(0, 8'h3c, 8'h00);
    chk(rd, 8'h14);
    apb(0, 8'h3c, 8'h00);
    chk(rd, 8'h00);
    apb(0, 8'h30, 8'h00);
    chk(rd, 8'h04);
    apb(1, 8'h44, 8'h01);
    apb(1, 8'h1c, 8'h05); repeat (3) @(posedge pclk);
    chk(8'({conv_en, vcc_en}), 8'h02);
    wait_on(1); chk(8'({conv_en, vcc_en, io_en}), 8'h07);
    repeat (2) @(posedge pclk); chk(8'(card_rst), 8'h01);
    chk(8'(irq), 8'h00);
    apb(1, 8'h1c, 8'h01); repeat (2) @(posedge pclk);
    chk(8'(card_rst), 8'h00);
    apb(1, 8'h1c, 8'h00); repeat (2) @(posedge pclk);
    chk(8'(card_clk_en), 8'h00);
    wait_on(0); chk(8'({vcc_en, io_en}), 8'h00);
    apb(1, 8'h1c, 8'h03); wait_on(1);
    short_cmd <= 1'b1;
    wait_on(0);
    short_cmd <= 1'b0;
    apb(0, 8'h1c, 8'h00); chk(rd, 8'h02);
    chk(8'(irq), 8'h01);
    apb(0, 8'h40, 8'h00); chk(rd & 8'h01, 8'h01);
    apb(1, 8'h40, 8'h0f); repeat (2) @(posedge pclk); chk(8'(irq), 8'h00);
    apb(0, 8'h10, 8'h00); chk(8'(err), 8'h01);
    apb(1, 8'h3c, 8'hff); chk(8'(err), 8'h01);
    results;
  end
endmodule
